// [rate_addr_block.sv]
/*
  Slave-address and bit-rate divider block with an AXI4-Lite register port
  and an address watcher on the shared two-wire bus.
  Assumes open-drain lines resolved outside; an enable high pulls a line low.
*/
// The AXI4-Lite register port and the register offsets were decided locally.
// Contract
// - Own-address bits 7:1 hold the address answered as slave, not sent.
// - Own-address bit 0 always reads zero whatever is written.
// - Block acts as slave by default, watching for its address.
// - Both registers are readable and writable at any time.
// - Rate code splits into multiplier, prescaler and tap fields.
// - Tap codes give period tap counts 5,6,7,8,9,10,12,15.
// - Tap codes give hold tap counts 1,1,2,2,3,3,4,4.
// - Prescaler codes give first-tap offsets 4,4,6,6,14,30,62,126.
// - Tap spacing is two to the prescaler code.
// - Multiplier codes 00,01,10 give 1,2,4; 11 reserved.
// - Period is multiplier times twice offset plus period span plus 2.
// - Data hold is multiplier times offset plus hold span plus 3.
// - Start hold is multiplier times start base plus period span.
// - Stop hold is multiplier times stop base plus period span.
// - Code 00 gives period 20, hold 7, start 6, stop 11.
// - Clock and data lines are shared bidirectional pins.
`timescale 1ns/1ps
module rate_addr_block
  import rate_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Two-wire bus clock line
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  // Two-wire bus data line
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_HOLD = 6'b000100,
    ST_ACK = 6'b001000,
    ST_REL = 6'b010000,
    ST_SKIP = 6'b100000
  } watch_e;

  rate_if rates ();

  logic sdaLevel;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  // Registers and their next values
  logic [7:0] ownAddr_reg, ownAddr_next;
  logic [7:0] rateCode_reg, rateCode_next;
  logic matched_reg, matched_next;
  logic busy_reg, busy_next;
  watch_e state_reg, state_next;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [15:0] holdCnt_reg, holdCnt_next;
  logic sdaOe_reg, sdaOe_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  logic writeNow;
  logic matchClear;
  logic matchSet;
  logic [31:0] readWord;
  logic readHit;
  logic writeHit;

  rate_decoder decoder (
    .rateCode(rateCode_reg),
    .rates(rates.src)
  );

  line_watch watch (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaLevel(sdaLevel),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  // Write lands while ready is up and both channels still offer
  assign writeNow = awready_reg && awvalid && wvalid;

  // Write decode; read-only words accept and ignore data
  always_comb begin
    case (awaddr[7:0])
      OFF_OWN_ADDR, OFF_DIVIDER, OFF_STATUS: writeHit = 1'b1;
      OFF_SCL_DIV, OFF_SDA_HOLD, OFF_SCL_HOLD: writeHit = 1'b1;
      default: writeHit = 1'b0;
    endcase
  end

  // Read decode; unmapped reads return zero with an error
  always_comb begin
    readHit = 1'b1;
    case (araddr[7:0])
      OFF_OWN_ADDR: readWord = {24'h000000, ownAddr_reg[7:1], 1'b0};
      OFF_DIVIDER: readWord = {24'h000000, rateCode_reg};
      OFF_STATUS: readWord = {29'h00000000, state_reg != ST_IDLE && state_reg != ST_SKIP, busy_reg, matched_reg};
      OFF_SCL_DIV: readWord = {16'h0000, rates.sclDivider};
      OFF_SDA_HOLD: readWord = {16'h0000, rates.sdaHold};
      OFF_SCL_HOLD: readWord = {rates.stopHold, rates.startHold};
      default: begin
        readWord = 32'h00000000;
        readHit = 1'b0;
      end
    endcase
  end

  // Bus handshake: ready pulses once, response follows both channels
  always_comb begin
    awready_next = 1'b0;
    wready_next = 1'b0;
    bvalid_next = bvalid_reg && !bready;
    bresp_next = bresp_reg;
    arready_next = 1'b0;
    rvalid_next = rvalid_reg && !rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (awvalid && wvalid && !awready_reg && !bvalid_reg) begin
      awready_next = 1'b1;
      wready_next = 1'b1;
    end
    if (writeNow) begin
      bvalid_next = 1'b1;
      bresp_next = writeHit ? RESP_OKAY : RESP_SLVERR;
    end
    if (arvalid && !arready_reg && !rvalid_reg) begin
      arready_next = 1'b1;
    end
    if (arready_reg && arvalid) begin
      rvalid_next = 1'b1;
      rdata_next = readWord;
      rresp_next = readHit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Register writes, no access restriction in any state
  assign matchClear = writeNow && awaddr[7:0] == OFF_STATUS && wstrb[0] && wdata[ST_MATCH_BIT];
  always_comb begin
    ownAddr_next = ownAddr_reg;
    rateCode_next = rateCode_reg;
    if (writeNow && wstrb[0] && awaddr[7:0] == OFF_OWN_ADDR) begin
      ownAddr_next = {wdata[7:1], 1'b0};
    end
    if (writeNow && wstrb[0] && awaddr[7:0] == OFF_DIVIDER) begin
      rateCode_next = wdata[7:0];
    end
  end

  // Address watcher; always listening as slave after reset
  always_comb begin
    state_next = state_reg;
    bitCnt_next = bitCnt_reg;
    shift_next = shift_reg;
    holdCnt_next = holdCnt_reg;
    sdaOe_next = sdaOe_reg;
    busy_next = busy_reg;
    matchSet = 1'b0;
    case (state_reg)
      ST_ADDR: begin
        if (sclRise) begin
          shift_next = {shift_reg[6:0], sdaLevel};
          bitCnt_next = bitCnt_reg + 4'h1;
        end
        if (sclFall && bitCnt_reg == ADDR_BITS) begin
          // Compare against the stored slave address only
          if (shift_reg[7:1] == ownAddr_reg[7:1]) begin
            state_next = ST_HOLD;
            holdCnt_next = rates.sdaHold;
            matchSet = 1'b1;
          end else begin
            state_next = ST_SKIP;
          end
        end
      end
      // Data only moves a hold time after the clock fell
      ST_HOLD: begin
        if (holdCnt_reg <= 16'h0001) begin
          sdaOe_next = 1'b1;
          state_next = ST_ACK;
        end else begin
          holdCnt_next = holdCnt_reg - 16'h0001;
        end
      end
      ST_ACK: begin
        if (sclFall) begin
          holdCnt_next = rates.sdaHold;
          state_next = ST_REL;
        end
      end
      ST_REL: begin
        if (holdCnt_reg <= 16'h0001) begin
          sdaOe_next = 1'b0;
          state_next = ST_SKIP;
        end else begin
          holdCnt_next = holdCnt_reg - 16'h0001;
        end
      end
      ST_IDLE, ST_SKIP: begin
        state_next = state_reg;
      end
      default: begin
        state_next = ST_IDLE;
        sdaOe_next = 1'b0;
      end
    endcase
    // Start and stop override any frame in progress
    if (startSeen) begin
      state_next = ST_ADDR;
      bitCnt_next = 4'h0;
      sdaOe_next = 1'b0;
      busy_next = 1'b1;
    end else if (stopSeen) begin
      state_next = ST_IDLE;
      sdaOe_next = 1'b0;
      busy_next = 1'b0;
    end
    // A new match outranks a clear in the same cycle
    matched_next = matchSet || (matched_reg && !matchClear);
  end

  // State registers; the enable freezes everything
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ownAddr_reg <= OWN_ADDR_RESET;
      rateCode_reg <= DIVIDER_RESET;
      matched_reg <= 1'b0;
      busy_reg <= 1'b0;
      state_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      holdCnt_reg <= 16'h0000;
      sdaOe_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (ce) begin
      ownAddr_reg <= ownAddr_next;
      rateCode_reg <= rateCode_next;
      matched_reg <= matched_next;
      busy_reg <= busy_next;
      state_reg <= state_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;
      holdCnt_reg <= holdCnt_next;
      sdaOe_reg <= sdaOe_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Clock line is never pulled; slave only, no clock stretching
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclOut <= 1'b0;
      sclOe <= 1'b0;
      sdaOut <= 1'b0;
    end else if (ce) begin
      sclOut <= 1'b0;
      sclOe <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  // Outputs straight from flops
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign sdaOe = sdaOe_reg;

endmodule // rate_addr_block

// [rate_pkg.sv]
/*
  Constants for the slave-address and bit-rate divider block: register
  offsets, field positions, reset values, decode tables and bus codes.
  Assumes nothing of its surroundings.
*/
package rate_pkg;

  // Register byte offsets on the AXI4-Lite port
  localparam logic [7:0] OFF_OWN_ADDR = 8'h00;
  localparam logic [7:0] OFF_DIVIDER = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_SCL_DIV = 8'h0c;
  localparam logic [7:0] OFF_SDA_HOLD = 8'h10;
  localparam logic [7:0] OFF_SCL_HOLD = 8'h14;

  // Reset values
  localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
  localparam logic [7:0] DIVIDER_RESET = 8'h00;

  // Field positions
  localparam int MUL_HI = 7;
  localparam int MUL_LO = 6;
  localparam int PRE_HI = 5;
  localparam int PRE_LO = 3;
  localparam int TAP_HI = 2;
  localparam int TAP_LO = 0;
  localparam int ST_MATCH_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_ACTIVE_BIT = 2;

  // Address frame length in bits
  localparam logic [3:0] ADDR_BITS = 4'h8;

  // Tap and prescaler tables, index is the field code
  localparam logic [3:0] SCL_TAP [0:7] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc, 4'hf};
  localparam logic [3:0] SDA_TAP [0:7] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h4};
  localparam logic [7:0] FIRST_TAP [0:7] = '{8'h04, 8'h04, 8'h06, 8'h06, 8'h0e, 8'h1e, 8'h3e, 8'h7e};
  localparam logic [7:0] START_BASE [0:7] = '{8'h02, 8'h02, 8'h02, 8'h06, 8'h0e, 8'h1e, 8'h3e, 8'h7e};
  localparam logic [7:0] STOP_BASE [0:7] = '{8'h07, 8'h07, 8'h09, 8'h09, 8'h11, 8'h21, 8'h41, 8'h81};
  // Multiplier as a left shift: 1, 2, 4; reserved code falls back to 1
  localparam logic [1:0] MUL_SHIFT [0:3] = '{2'h0, 2'h1, 2'h2, 2'h0};
  localparam logic [15:0] PERIOD_ADD = 16'h0002;
  localparam logic [15:0] HOLD_ADD = 16'h0003;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [rate_if.sv]
/*
  Carries the four derived timing values from the decoder to the block top.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface rate_if;
  logic [15:0] sclDivider;
  logic [15:0] sdaHold;
  logic [15:0] startHold;
  logic [15:0] stopHold;
  modport src (output sclDivider, output sdaHold, output startHold, output stopHold);
  modport dst (input sclDivider, input sdaHold, input startHold, input stopHold);
endinterface

// [rate_decoder.sv]
/*
  Decodes the 8-bit rate code into serial clock period, data hold and the
  start and stop clock holds. Purely combinational; the code is a register.
*/
`timescale 1ns/1ps
module rate_decoder
  import rate_pkg::*;
(
  // Rate code
  input wire logic [7:0] rateCode,
  // Derived values
  rate_if.src rates
);
  logic [1:0] mulCode;
  logic [2:0] preCode;
  logic [2:0] tapCode;
  logic [1:0] mulShift;
  logic [15:0] periodSpan;
  logic [15:0] holdSpan;

  // Split the code into its three fields
  assign mulCode = rateCode[MUL_HI:MUL_LO];
  assign preCode = rateCode[PRE_HI:PRE_LO];
  assign tapCode = rateCode[TAP_HI:TAP_LO];
  assign mulShift = MUL_SHIFT[mulCode];

  // Tap distance is a shift since spacing is a power of two
  assign periodSpan = {12'h000, SCL_TAP[tapCode] - 4'h1} << preCode;
  assign holdSpan = {12'h000, SDA_TAP[tapCode] - 4'h1} << preCode;

  // Final values, code 00 gives 20, 7, 6, 11
  assign rates.sclDivider = (({8'h00, FIRST_TAP[preCode]} + periodSpan + PERIOD_ADD) << 1) << mulShift;
  assign rates.sdaHold = ({8'h00, FIRST_TAP[preCode]} + holdSpan + HOLD_ADD) << mulShift;
  assign rates.startHold = ({8'h00, START_BASE[preCode]} + periodSpan) << mulShift;
  assign rates.stopHold = ({8'h00, STOP_BASE[preCode]} + periodSpan) << mulShift;
endmodule // rate_decoder

// [line_watch.sv]
/*
  Synchronises the two bus lines and reports clock edges, start and stop.
  Assumes the lines are asynchronous to clock.
*/
`timescale 1ns/1ps
module line_watch (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Raw line levels
  input wire logic sclIn,
  input wire logic sdaIn,
  // Data level, and clock, start and stop events of one cycle each
  output logic sdaLevel,
  output logic sclRise,
  output logic sclFall,
  output logic startSeen,
  output logic stopSeen
);
  logic [1:0] meta_reg, meta_next;
  logic [1:0] sync_reg, sync_next;
  logic [1:0] prev_reg, prev_next;

  // Two stages, then one for edge history; bit 0 clock, bit 1 data
  always_comb begin
    meta_next = {sdaIn, sclIn};
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
      prev_reg <= 2'h3;
    end else if (ce) begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // Data moving while clock is high marks start or stop
  assign sdaLevel = sync_reg[1];
  assign sclRise = sync_reg[0] && !prev_reg[0];
  assign sclFall = !sync_reg[0] && prev_reg[0];
  assign startSeen = sync_reg[0] && prev_reg[0] && prev_reg[1] && !sync_reg[1];
  assign stopSeen = sync_reg[0] && prev_reg[0] && !prev_reg[1] && sync_reg[1];
endmodule // line_watch

// [rate_addr_block_chk.sv]
/*
  Port-level checker for the rate and address block.
  Assumes a single clock and ce held high by the bench.
*/
`timescale 1ns/1ps
module rate_addr_block_chk
  import rate_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  // Two-wire lines
  input wire logic sclOe,
  input wire logic sclOut,
  input wire logic sdaOut
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [7:0] readAddr_reg;
  logic [7:0] readAddr_next;
  // Address of the read in flight, so its data can be judged
  always_comb begin
    readAddr_next = readAddr_reg;
    if (arvalid && arready) readAddr_next = araddr[7:0];
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) readAddr_reg <= 8'h00;
    else readAddr_reg <= readAddr_next;
  end
  write_pair_a: assert property (awready |-> wready) else $error("write channels taken apart");
  write_answer_a: assert property (awready |=> bvalid && !awready) else $error("no write response");
  read_answer_a: assert property (arready |=> rvalid && !arready) else $error("no read data");
  bvalid_drop_a: assert property (bvalid && bready |=> !bvalid) else $error("response not retired");
  rvalid_drop_a: assert property (rvalid && rready |=> !rvalid) else $error("read not retired");
  addr_bit0_a: assert property (rvalid && readAddr_reg == OFF_OWN_ADDR |->
    rdata[0] == 1'b0 && rdata[31:8] == 24'h0) else $error("own address reads bit 0 set");
  period_even_a: assert property (rvalid && readAddr_reg == OFF_SCL_DIV |->
    rdata[0] == 1'b0 && rdata[31:16] == 16'h0) else $error("odd clock period");
  hold_order_a: assert property (rvalid && readAddr_reg == OFF_SCL_HOLD |->
    rdata[31:16] > rdata[15:0]) else $error("stop hold not above start hold");
  clock_free_a: assert property (!sclOe && !sclOut && !sdaOut) else $error("line driven high or clock driven");
endmodule // rate_addr_block_chk

// [bus_master_model.sv]
/*
  Behavioural master on the two-wire bus: start, address byte, ack bit, stop.
  Assumes pull-ups and wired-AND resolution in the bench.
*/
`timescale 1ns/1ps
module bus_master_model #(
  parameter int HALF = 30
) (
  // Clock
  input wire logic clock,
  // Resolved data line
  input wire logic sdaLine,
  // Releases, high lets the pull-up win
  output logic sclRel,
  output logic sdaRel
);
  // Idle bus: both lines released
  initial begin
    sclRel = 1'b1;
    sdaRel = 1'b1;
  end
  task automatic waitHalf();
    repeat (HALF) @(posedge clock);
  endtask
  // Long low phase leaves room for the slave's hold delay
  task automatic sendAddr(input logic [7:0] addr, output logic acked);
    sdaRel <= 1'b0;
    waitHalf();
    for (int i = 7; i >= 0; i--) begin
      sclRel <= 1'b0;
      waitHalf();
      sdaRel <= addr[i];
      waitHalf();
      sclRel <= 1'b1;
      waitHalf();
      waitHalf();
    end
    sclRel <= 1'b0;
    waitHalf();
    sdaRel <= 1'b1;
    waitHalf();
    sclRel <= 1'b1;
    waitHalf();
    acked = !sdaLine;
    waitHalf();
    sclRel <= 1'b0;
    waitHalf();
    sdaRel <= 1'b0;
    waitHalf();
    sclRel <= 1'b1;
    waitHalf();
    sdaRel <= 1'b1;
    waitHalf();
  endtask
endmodule // bus_master_model

// [test_rate_addr_block.sv]
/*
  Self-checking bench for the rate and address block.
  Assumes the checker and bus master model are compiled first.
*/
`timescale 1ns/1ps
module test_rate_addr_block;
  import rate_pkg::*;
  logic clock, rst, ce, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic sclOut, sclOe, sdaOut, sdaOe, sclRel, sdaRel, sclLine, sdaLine;
  int n_errors, num_checks;
  int periodTap [8] = '{5, 6, 7, 8, 9, 10, 12, 15};
  int holdTap [8] = '{1, 1, 2, 2, 3, 3, 4, 4};
  int firstTap [8] = '{4, 4, 6, 6, 14, 30, 62, 126};
  int startBase [8] = '{2, 2, 2, 6, 14, 30, 62, 126};
  int stopBase [8] = '{7, 7, 9, 9, 17, 33, 65, 129};
  // Wired-AND with pull-ups on both lines
  assign sclLine = sclRel & ~sclOe;
  assign sdaLine = sdaRel & ~sdaOe;
  always #4 clock = ~clock;
  rate_addr_block i_rate_addr_block (.clock(clock), .rst(rst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
  bus_master_model i_bus_master_model (.clock(clock), .sdaLine(sdaLine), .sclRel(sclRel), .sdaRel(sdaRel));
  task automatic results();
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    num_checks++;
    if (seen !== expected) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask
  // Both channels offered together, each released when taken
  task automatic axiWrite(input logic [7:0] addr, input logic [31:0] data, input logic [3:0] strb, output logic [1:0] resp);
    int k;
    @(posedge clock);
    awaddr <= addr;
    wdata <= data;
    wstrb <= strb;
    {awvalid, wvalid, bready} <= 3'h7;
    for (k = 0; k < 50 && !bvalid; k++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    resp = bresp;
    bready <= 1'b0;
    if (k == 50) n_errors++;
    if (k == 50) results();
  endtask
  task automatic axiRead(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
    int k;
    @(posedge clock);
    araddr <= addr;
    {arvalid, rready} <= 2'h3;
    for (k = 0; k < 50 && !rvalid; k++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (k == 50) n_errors++;
    if (k == 50) results();
  endtask
  // Reset code, read-only word and an unmapped address
  task automatic resetAndMap();
    logic [31:0] d;
    logic [1:0] r;
    axiRead(OFF_OWN_ADDR, d, r);
    check(d, {24'h0, OWN_ADDR_RESET});
    axiWrite(OFF_SCL_DIV, 32'h5, 4'hf, r);
    axiRead(OFF_SCL_DIV, d, r);
    check(d, 32'd20);
    axiRead(OFF_SDA_HOLD, d, r);
    check(d, 32'd7);
    axiRead(OFF_SCL_HOLD, d, r);
    check(d, {16'd11, 16'd6});
    axiWrite(8'h40, 32'h1, 4'hf, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axiRead(8'h40, d, r);
    check(d, 32'h0);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask
  task automatic ownAddress();
    logic [31:0] d;
    logic [1:0] r;
    axiWrite(OFF_OWN_ADDR, 32'hffffffff, 4'hf, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    axiRead(OFF_OWN_ADDR, d, r);
    check(d, 32'hfe);
    axiWrite(OFF_OWN_ADDR, 32'h5b, 4'h1, r);
    axiRead(OFF_OWN_ADDR, d, r);
    check(d, 32'h5a);
  endtask
  // Every code but the reserved multiplier, values worked out here
  task automatic rateSweep();
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] code;
    int m, p, t, sp, span;
    for (int c = 0; c < 192; c++) begin
      code = c[7:0];
      m = 1 << code[7:6];
      p = code[5:3];
      t = code[2:0];
      sp = 1 << p;
      span = (periodTap[t] - 1) * sp;
      axiWrite(OFF_DIVIDER, {24'h0, code}, 4'h1, r);
      axiRead(OFF_DIVIDER, d, r);
      check(d, {24'h0, code});
      axiRead(OFF_SCL_DIV, d, r);
      check(d, 32'(m * 2 * (firstTap[p] + span + 2)));
      axiRead(OFF_SDA_HOLD, d, r);
      check(d, 32'(m * (firstTap[p] + (holdTap[t] - 1) * sp + 3)));
      axiRead(OFF_SCL_HOLD, d, r);
      check(d, {16'(m * (stopBase[p] + span)), 16'(m * (startBase[p] + span))});
    end
  endtask
  // Matching frame sets the sticky flag, a clear drops it, a foreign frame leaves it low
  task automatic slaveMatch();
    logic [31:0] d;
    logic [1:0] r;
    logic acked;
    axiWrite(OFF_DIVIDER, 32'h0, 4'h1, r);
    axiWrite(OFF_OWN_ADDR, 32'ha4, 4'h1, r);
    i_bus_master_model.sendAddr(8'ha5, acked);
    check({31'h0, acked}, 32'h1);
    axiRead(OFF_STATUS, d, r);
    check(d, 32'h1);
    axiWrite(OFF_STATUS, 32'h1, 4'h1, r);
    axiRead(OFF_STATUS, d, r);
    check(d, 32'h0);
    i_bus_master_model.sendAddr(8'h24, acked);
    check({31'h0, acked}, 32'h0);
    axiRead(OFF_STATUS, d, r);
    check(d, 32'h0);
  endtask
  // Main sequence
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wstrb, wdata} = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    resetAndMap();
    ownAddress();
    rateSweep();
    slaveMatch();
    results();
  end
endmodule // test_rate_addr_block
bind rate_addr_block rate_addr_block_chk #(.ADDR_W(ADDR_W)) i_rate_addr_block_chk (.clock(clock), .rst(rst),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready), .sclOe(sclOe),
  .sclOut(sclOut), .sdaOut(sdaOut));
